/* File: rtl/cmr_pkg.sv */
// Purpose: constants and carrier types for the cell monitor control register bank
// Assumes: 10 MHz device clock, byte-wide register access from the link front end
// Notes: constants are shared by the bank and by the bench
package cmr_pkg;
  // register offsets
  localparam logic [7:0] OFS_OVER = 8'h22;
  localparam logic [7:0] OFS_UNDER = 8'h23;
  localparam logic [7:0] OFS_PAR_LOW = 8'h24;
  localparam logic [7:0] OFS_PAR_HIGH = 8'h25;
  localparam logic [7:0] OFS_SETUP = 8'h30;
  localparam logic [7:0] OFS_PIN = 8'h31;
  localparam logic [7:0] OFS_BAL_EN = 8'h32;
  localparam logic [7:0] OFS_BAL_TIME = 8'h33;
  localparam logic [7:0] OFS_CONVERSION_START_BIT = 8'h34;
  localparam logic [7:0] OFS_KEY = 8'h3A;
  localparam logic [7:0] OFS_ADDR = 8'h3B;
  localparam logic [7:0] OFS_PROT_FIRST = 8'h40;
  localparam logic [7:0] OFS_PROT_LAST = 8'h4F;
  // key values
  localparam logic [7:0] KEY_UNLOCK = 8'h35;
  localparam logic [7:0] KEY_RELOAD = 8'h27;
  localparam logic [5:0] ADDR_BROADCAST = 6'h3F;
  // reset values
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [5:0] RST_BAL_EN = 6'h00;
  localparam logic [7:0] RST_BAL_TIME = 8'h00;
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  // field positions
  localparam int SETUP_ON_BIT = 6;
  localparam int SETUP_TEMP_LSB = 4;
  localparam int SETUP_GENERAL_ANALOG_INPUT_BIT = 3;
  localparam int PIN_AUX_BIT = 7;
  localparam int PIN_GOUT_BIT = 6;
  localparam int PIN_LOWPWR_BIT = 2;
  localparam int BALT_UNIT_BIT = 7;
  localparam int ADDR_DONE_BIT = 7;
  localparam int CONVERSION_START_BIT_BIT = 0;
  // writable masks, unimplemented bits read zero
  localparam logic [7:0] MASK_SETUP = 8'h7F;
  localparam logic [7:0] MASK_PIN = 8'hC7;
  localparam logic [7:0] MASK_BAL_TIME = 8'hBF;
  localparam logic [7:0] MASK_ADDR = 8'hBF;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLEEP_SETTLE_MS = 1;
  localparam int SLEEP_SETTLE_CYCLES = SLEEP_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BAL_TICK_S = 1;
  localparam int BAL_TICK_CYCLES = BAL_TICK_S * 1000000000 / CLK_PERIOD_NS;
  localparam int MINUTE_SECONDS = 60;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmr_req_t;

  typedef struct packed {
    logic adcPower;
    logic convStart;
    logic [1:0] tempSel;
    logic gpaiSel;
    logic [5:0] cellMask;
  } cmr_meas_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] pinCtrl;
    logic [5:0] balEnable;
    logic [7:0] balTime;
    logic [7:0] key;
    logic [7:0] addr;
    logic convPulse;
    logic convBusy;
    logic monitorOn;
    logic [23:0] settleCnt;
    logic [23:0] tickCnt;
    logic [11:0] secCnt;
    logic balExpired;
    logic [5:0] overFlags;
    logic [5:0] underFlags;
    logic [7:0] rdata;
    logic gpioSync1;
    logic gpioSync2;
    logic protWrite;
    logic [7:0] protAddr;
    logic [7:0] protData;
  } cmr_state_t;
endpackage

/* File: rtl/cmr_control_regs.sv */
// Purpose: control and status register bank of a stackable cell monitor
// Assumes: link front end hands over one decoded byte access per request
// Notes: converter, comparators and protected group live outside this block
`timescale 1ns/1ns
module cmr_control_regs #(
  parameter int SETTLE_CYCLES = cmr_pkg::SLEEP_SETTLE_CYCLES,
  parameter int TICK_CYCLES = cmr_pkg::BAL_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire cmr_pkg::cmr_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic [5:0] cellOverRaw,
  input wire logic [5:0] cellUnderRaw,
  input wire logic [1:0] seriesCount,
  input wire logic [7:0] parityLow,
  input wire logic [3:0] parityHigh,
  input wire logic convDone,
  input wire logic reloadDone,
  input wire logic gpioPinIn,
  output logic gpioPinOut,
  output logic gpioDriveEn_n,
  output cmr_pkg::cmr_meas_t measure,
  output logic auxConnect,
  output logic lowPower,
  output logic monitorActive,
  output logic [1:0] sensorGround,
  output logic [5:0] balancePin,
  output logic overvoltageSummary,
  output logic undervoltageSummary,
  output logic protWrite,
  output logic [7:0] protAddr,
  output logic [7:0] protData,
  output logic reloadReq,
  output logic [5:0] linkAddress,
  output logic addressAssigned
);
  import cmr_pkg::*;

  // refuse counts the counters cannot hold
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 16777215) begin : g_bad_settle
    $error("settle count out of range");
  end
  if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_bad_tick
    $error("tick count out of range");
  end

  cmr_state_t s;
  cmr_state_t next_s;
  logic balRunning;
  logic [11:0] balLimit;
  logic keyOpen;

  // cumulative cell selection, unused codes fall back to cell one
  function automatic logic [5:0] cellSelMask(input logic [2:0] code);
    case (code)
      3'h0: cellSelMask = 6'h01;
      3'h1: cellSelMask = 6'h03;
      3'h2: cellSelMask = 6'h07;
      3'h3: cellSelMask = 6'h0F;
      3'h4: cellSelMask = 6'h1F;
      3'h5: cellSelMask = 6'h3F;
      default: cellSelMask = 6'h01;
    endcase
  endfunction

  // cells actually wired, upper cells masked off
  function automatic logic [5:0] seriesMask(input logic [1:0] code);
    case (code)
      2'h0: seriesMask = 6'h3F;
      2'h1: seriesMask = 6'h1F;
      2'h2: seriesMask = 6'h0F;
      default: seriesMask = 6'h07;
    endcase
  endfunction

  // balance timer limit in seconds
  assign balLimit = s.balTime[BALT_UNIT_BIT] ?
    12'(s.balTime[5:0] * MINUTE_SECONDS) : {6'h00, s.balTime[5:0]};
  assign balRunning = (|s.balEnable) && (s.balTime[5:0] != 6'h00)
    && !s.balExpired;
  assign keyOpen = (s.key == KEY_UNLOCK);

  // next state of the whole bank
  always_comb begin
    next_s = s;
    next_s.convPulse = 1'b0;
    next_s.protWrite = 1'b0;
    // pin level through two flops before anything reads it
    next_s.gpioSync1 = gpioPinIn;
    next_s.gpioSync2 = s.gpioSync1;

    // comparators stop in low power and resume after settling
    if (s.pinCtrl[PIN_LOWPWR_BIT]) begin
      next_s.monitorOn = 1'b0;
      next_s.settleCnt = 24'h000000;
    end else if (!s.monitorOn) begin
      if (s.settleCnt == 24'(SETTLE_CYCLES - 1)) begin
        next_s.monitorOn = 1'b1;
        next_s.settleCnt = 24'h000000;
      end else begin
        next_s.settleCnt = s.settleCnt + 24'h000001;
      end
    end

    // flags follow the comparators while monitoring, unused cells masked
    if (s.monitorOn) begin
      next_s.overFlags = cellOverRaw & seriesMask(seriesCount);
      next_s.underFlags = cellUnderRaw & seriesMask(seriesCount);
    end else begin
      next_s.overFlags = 6'h00;
      next_s.underFlags = 6'h00;
    end

    // conversion busy until the converter reports done
    if (convDone) begin
      next_s.convBusy = 1'b0;
    end

    // balance safety timer, counts only while a balance output is on
    if (balRunning) begin
      if (s.tickCnt == 24'(TICK_CYCLES - 1)) begin
        next_s.tickCnt = 24'h000000;
        next_s.secCnt = s.secCnt + 12'h001;
        if (s.secCnt + 12'h001 >= balLimit) begin
          next_s.balExpired = 1'b1;
        end
      end else begin
        next_s.tickCnt = s.tickCnt + 24'h000001;
      end
    end

    // reload finished, key returns to zero
    if (reloadDone && s.key == KEY_RELOAD) begin
      next_s.key = 8'h00;
    end

    // register reads, answered one cycle later
    if (regReq.read) begin
      case (regReq.addr)
        OFS_OVER: next_s.rdata = {2'b00, s.overFlags};
        OFS_UNDER: next_s.rdata = {2'b00, s.underFlags};
        OFS_PAR_LOW: next_s.rdata = parityLow;
        OFS_PAR_HIGH: next_s.rdata = {4'h0, parityHigh};
        OFS_SETUP: next_s.rdata = s.setup;
        OFS_PIN: next_s.rdata = {s.pinCtrl[7:6], s.gpioSync2, s.pinCtrl[4:0]};
        OFS_BAL_EN: next_s.rdata = {2'b00, s.balEnable};
        OFS_BAL_TIME: next_s.rdata = s.balTime;
        OFS_ADDR: next_s.rdata = s.addr;
        default: next_s.rdata = 8'h00;
      endcase
    end

    // register writes; a new write wins over a same-cycle completion
    if (regReq.write) begin
      // any write but the key itself clears the key
      next_s.key = 8'h00;
      case (regReq.addr)
        OFS_SETUP: next_s.setup = regReq.wdata & MASK_SETUP;
        OFS_PIN: next_s.pinCtrl = regReq.wdata & MASK_PIN;
        OFS_BAL_EN: begin
          next_s.balEnable = regReq.wdata[5:0];
          next_s.balExpired = 1'b0;
          next_s.tickCnt = 24'h000000;
          next_s.secCnt = 12'h000;
        end
        OFS_BAL_TIME: begin
          next_s.balTime = regReq.wdata & MASK_BAL_TIME;
          next_s.balExpired = 1'b0;
          next_s.tickCnt = 24'h000000;
          next_s.secCnt = 12'h000;
        end
        OFS_CONVERSION_START_BIT: begin
          if (regReq.wdata[CONVERSION_START_BIT_BIT]) begin
            next_s.convPulse = 1'b1;
            next_s.convBusy = 1'b1;
          end
        end
        OFS_KEY: next_s.key = regReq.wdata;
        OFS_ADDR: next_s.addr = regReq.wdata & MASK_ADDR;
        default: begin
          // protected group writes pass only while unlocked
          if (regReq.addr >= OFS_PROT_FIRST && regReq.addr <= OFS_PROT_LAST
              && keyOpen) begin
            next_s.protWrite = 1'b1;
            next_s.protAddr = regReq.addr;
            next_s.protData = regReq.wdata;
          end
        end
      endcase
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= '0;
      s.setup <= RST_SETUP;
      s.pinCtrl <= RST_PIN;
      s.balEnable <= RST_BAL_EN;
      s.balTime <= RST_BAL_TIME;
      s.key <= RST_KEY;
      s.addr <= RST_ADDR;
      s.monitorOn <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // balance outputs, forced low on expiry or zero time
  for (genvar i = 0; i < 6; i++) begin : g_bal
    assign balancePin[i] = s.balEnable[i] & balRunning;
  end

  // measurement controls toward the converter
  assign measure.adcPower = s.setup[SETUP_ON_BIT] | s.convBusy;
  assign measure.convStart = s.convPulse;
  assign measure.tempSel = s.setup[SETUP_TEMP_LSB +: 2];
  assign measure.gpaiSel = s.setup[SETUP_GENERAL_ANALOG_INPUT_BIT];
  assign measure.cellMask = cellSelMask(s.setup[2:0]);

  // pins and modes; open drain only ever pulls low
  assign auxConnect = s.pinCtrl[PIN_AUX_BIT];
  assign gpioPinOut = 1'b0;
  assign gpioDriveEn_n = s.pinCtrl[PIN_GOUT_BIT];
  assign lowPower = s.pinCtrl[PIN_LOWPWR_BIT];
  assign monitorActive = s.monitorOn;
  assign sensorGround = s.pinCtrl[1:0];
  assign overvoltageSummary = |s.overFlags;
  assign undervoltageSummary = |s.underFlags;
  assign regRdata = s.rdata;
  assign protWrite = s.protWrite;
  assign protAddr = s.protAddr;
  assign protData = s.protData;
  assign reloadReq = (s.key == KEY_RELOAD);
  assign linkAddress = s.addr[5:0];
  assign addressAssigned = s.addr[ADDR_DONE_BIT];

  // checks next to the logic they guard
  a_key_reads_zero: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.read && regReq.addr == OFS_KEY) |=> (regRdata == 8'h00))
    else $error("key register read back nonzero");

  a_conversion_start_bit_single_pulse: assert property (@(posedge clock) disable iff (!rstn)
    measure.convStart |=> !measure.convStart)
    else $error("conversion start longer than one cycle");

  a_conversion_start_bit_from_write: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_CONVERSION_START_BIT && regReq.wdata[0])
    |=> (measure.convStart && measure.adcPower))
    else $error("conversion write did not start converter");

  a_key_cleared: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr != OFS_KEY) |=> !reloadReq && !keyOpen)
    else $error("key survived another write");

  a_prot_locked: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_PROT_FIRST && !keyOpen) |=> !protWrite)
    else $error("protected write passed while locked");

  a_prot_unlocked: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_PROT_LAST && keyOpen)
    |=> (protWrite && protAddr == OFS_PROT_LAST))
    else $error("protected write lost while unlocked");

  a_sleep_settle: assert property (@(posedge clock) disable iff (!rstn)
    $fell(lowPower) |-> (!monitorActive)[*8])
    else $error("monitoring resumed before settling");

  a_sleep_flags: assert property (@(posedge clock) disable iff (!rstn)
    lowPower |=> ##1 (!overvoltageSummary && !undervoltageSummary))
    else $error("fault flags active in low power");

  a_bal_zero_time: assert property (@(posedge clock) disable iff (!rstn)
    (s.balTime[5:0] == 6'h00) |-> (balancePin == 6'h00))
    else $error("balance active with zero time");

  a_bal_enable: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_BAL_EN && s.balTime[5:0] != 6'h00)
    |=> (balancePin == $past(regReq.wdata[5:0])))
    else $error("balance outputs do not follow enables");

  a_bal_expiry: assert property (@(posedge clock) disable iff (!rstn)
    s.balExpired |-> (balancePin == 6'h00))
    else $error("balance still active after timeout");

  a_series_mask: assert property (@(posedge clock) disable iff (!rstn)
    (seriesCount == 2'h3) |=> (s.overFlags[5:3] == 3'h0 && s.underFlags[5:3] == 3'h0))
    else $error("unused cell flag reported");

  // reset state, checked without the reset gate so the reset edge is covered
  a_reset_state: assert property (@(posedge clock)
    !rstn
    |=> (monitorActive && balancePin == 6'h00 && !protWrite && !reloadReq))
    else $error("bank busy after reset");

  // summaries follow the masked comparators one cycle later
  a_over_summary: assert property (@(posedge clock) disable iff (!rstn)
    (monitorActive && |(cellOverRaw & seriesMask(seriesCount)))
    |=> overvoltageSummary)
    else $error("overvoltage summary missed");

  a_under_summary: assert property (@(posedge clock) disable iff (!rstn)
    (monitorActive && |(cellUnderRaw & seriesMask(seriesCount)))
    |=> undervoltageSummary)
    else $error("undervoltage summary missed");

  a_sleep_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !monitorActive
    |=> (!overvoltageSummary && !undervoltageSummary))
    else $error("flags live while comparators off");

  // reserved and write-only places never leak stored bits
  a_setup_reserved: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.read && regReq.addr == OFS_SETUP)
    |=> !regRdata[7])
    else $error("setup top bit read as one");

  a_pin_reserved: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.read && regReq.addr == OFS_PIN)
    |=> (regRdata[4:3] == 2'b00))
    else $error("pin reserved bits read as one");

  a_conversion_start_bit_reads_zero: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.read && regReq.addr == OFS_CONVERSION_START_BIT)
    |=> (regRdata == 8'h00))
    else $error("start register read nonzero");

  a_parity_upper: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.read && regReq.addr == OFS_PAR_HIGH)
    |=> (regRdata[7:4] == 4'h0))
    else $error("parity upper bits nonzero");

  // converter controls follow the setup word and the end of a conversion
  a_adc_release: assert property (@(posedge clock) disable iff (!rstn)
    (convDone && !s.setup[SETUP_ON_BIT] && !regReq.write)
    |=> !measure.adcPower)
    else $error("converter stayed on in auto mode");

  a_setup_follow: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_SETUP)
    |=> ({measure.tempSel, measure.gpaiSel} == $past(regReq.wdata[5:3])))
    else $error("setup select fields wrong");

  a_cell_mask_low: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_SETUP && regReq.wdata[2:1] == 2'b11)
    |=> (measure.cellMask == 6'h01))
    else $error("unused cell code not cell one");

  // key and protected write handling
  a_reload_clear: assert property (@(posedge clock) disable iff (!rstn)
    (reloadDone && reloadReq && !regReq.write)
    |=> !reloadReq)
    else $error("reload key kept after completion");

  a_prot_data: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr inside {[OFS_PROT_FIRST:OFS_PROT_LAST]} && keyOpen)
    |=> (protWrite && protData == $past(regReq.wdata)))
    else $error("protected data lost");

  a_prot_pulse: assert property (@(posedge clock) disable iff (!rstn)
    protWrite
    |=> !protWrite)
    else $error("second protected write on one key");

  // pin and address registers drive their outputs directly
  a_pin_follow: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_PIN)
    |=> ({auxConnect, gpioDriveEn_n, lowPower, sensorGround}
      == $past({regReq.wdata[7:6], regReq.wdata[2:0]})))
    else $error("pin outputs do not follow write");

  a_addr_follow: assert property (@(posedge clock) disable iff (!rstn)
    (regReq.write && regReq.addr == OFS_ADDR)
    |=> ({addressAssigned, linkAddress} == $past({regReq.wdata[7], regReq.wdata[5:0]})))
    else $error("address outputs do not follow write");
endmodule

/* File: bench/cmr_host_model.sv */
// Purpose: host controller model issuing byte register accesses to the bank
// Assumes: one access at a time, request raised and dropped on rising edges
// Notes: a released request shows inverted address and data, never stale values
`timescale 1ns/1ns
module cmr_host_model (
  input wire logic clock,
  output cmr_pkg::cmr_req_t regReq,
  input wire logic [7:0] regRdata
);
  import cmr_pkg::*;

  // idle bus until the first access
  initial begin
    regReq = '0;
  end

  // single write; reserved setup and pin bits always go out as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == OFS_SETUP) v[7] = 1'b0;
    if (a == OFS_PIN) v[4:3] = 2'b00;
    @(posedge clock);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~v};
  endtask

  // single read; answer is taken once the take edge has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
    #1 d = regRdata;
  endtask

  // protected write always preceded by the unlock key
  task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_KEY, KEY_UNLOCK);
    wr(a, d);
  endtask

  // address first, assigned flag only once the address is in place
  task automatic assign_addr(input logic [5:0] a);
    wr(OFS_ADDR, {2'b00, a});
    wr(OFS_ADDR, {2'b10, a});
  endtask
endmodule

/* File: bench/tb.sv */
// Purpose: self-checking bench for the control register bank
// Assumes: short settle and tick counts so timed behaviour fits the run
// Notes: gpio wire has a pull-up; the bench may pull it low from outside
`timescale 1ns/1ns
module tb;
  import cmr_pkg::*;
  localparam int SETTLE = 20;
  localparam int TICK = 50;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  cmr_req_t regReq;
  cmr_meas_t measure;
  logic [7:0] regRdata, protAddr, protData, rv;
  logic [7:0] parityLow = 8'h00;
  logic [5:0] cellOverRaw = 6'h00, cellUnderRaw = 6'h00, balancePin, linkAddress;
  logic [3:0] parityHigh = 4'h0;
  logic [1:0] seriesCount = 2'b00, sensorGround;
  logic convDone = 1'b0, reloadDone = 1'b0, extLow = 1'b0, gpioPinOut, gpioDriveEn_n;
  logic auxConnect, lowPower, monitorActive, overvoltageSummary, undervoltageSummary;
  logic protWrite, reloadReq, addressAssigned;
  wire logic pinLevel;
  int error_cnt = 0, tests_run = 0, cycles = 0, protCnt = 0, convCnt = 0;

  // open-drain wire: low when the bank drives or the bench pulls, else pulled up
  assign pinLevel = (gpioDriveEn_n | gpioPinOut) & ~extLow;

  cmr_control_regs #(.SETTLE_CYCLES(SETTLE), .TICK_CYCLES(TICK)) i_cmr_control_regs (
    .clock(clock), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .cellOverRaw(cellOverRaw), .cellUnderRaw(cellUnderRaw), .seriesCount(seriesCount),
    .parityLow(parityLow), .parityHigh(parityHigh), .convDone(convDone),
    .reloadDone(reloadDone), .gpioPinIn(pinLevel), .gpioPinOut(gpioPinOut),
    .gpioDriveEn_n(gpioDriveEn_n), .measure(measure), .auxConnect(auxConnect),
    .lowPower(lowPower), .monitorActive(monitorActive), .sensorGround(sensorGround),
    .balancePin(balancePin), .overvoltageSummary(overvoltageSummary),
    .undervoltageSummary(undervoltageSummary), .protWrite(protWrite), .protAddr(protAddr),
    .protData(protData), .reloadReq(reloadReq), .linkAddress(linkAddress),
    .addressAssigned(addressAssigned));

  cmr_host_model i_cmr_host_model (.clock(clock), .regReq(regReq), .regRdata(regRdata));

  // 10 MHz clock
  initial begin
    forever #50 clock = ~clock;
  end

  // pulse counters, so pulse checks do not hinge on the exact cycle
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (protWrite === 1'b1) protCnt <= protCnt + 1;
    if (measure.convStart === 1'b1) convCnt <= convCnt + 1;
    if (cycles == 30000) begin
      error_cnt++;
      $display("wrong value at %0t: run limit reached", $time);
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_cmr_host_model.rd(a, rv);
    chk(rv, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // reset values, write-only places and an unmapped place all read zero
  task automatic t_reset();
    logic [7:0] ofs[8] = '{OFS_SETUP, OFS_PIN, OFS_BAL_EN, OFS_BAL_TIME, OFS_CONVERSION_START_BIT, OFS_KEY,
                           OFS_ADDR, 8'h50};
    foreach (ofs[i]) rdchk(ofs[i], 8'h00, "reset value");
    chk({gpioDriveEn_n, balancePin, addressAssigned}, 8'h00, "reset outputs");
    chk({7'h00, gpioPinOut}, 8'h00, "pin drive level");
    chk({7'h00, monitorActive}, 8'h01, "monitor after reset");
    $display("test reset done");
  endtask

  // every cell select code, with the other setup fields walked alongside
  task automatic t_setup();
    logic [7:0] v;
    for (int k = 0; k < 8; k++) begin
      v = {1'b0, k[0], k[1:0], k[0], k[2:0]};
      i_cmr_host_model.wr(OFS_SETUP, v);
      #1;
      chk({measure.adcPower, measure.tempSel, measure.gpaiSel, 4'h0}, {v[6:3], 4'h0},
          "setup fields");
      chk({2'b00, measure.cellMask}, {2'b00, (k > 5) ? 6'h01 : 6'h3F >> (5 - k)},
          "cell mask");
      rdchk(OFS_SETUP, v, "setup readback");
    end
    $display("test setup done");
  endtask

  // auto power mode: on for the conversion, off once it is done
  task automatic t_conversion_start_bit();
    int c0;
    i_cmr_host_model.wr(OFS_SETUP, 8'h00);
    c0 = convCnt;
    i_cmr_host_model.wr(OFS_CONVERSION_START_BIT, 8'h01);
    cyc(3);
    chk(8'(convCnt - c0), 8'h01, "one start pulse");
    chk({7'h00, measure.adcPower}, 8'h01, "converter on for request");
    rdchk(OFS_CONVERSION_START_BIT, 8'h00, "start bit reads zero");
    @(posedge clock) convDone <= 1'b1;
    @(posedge clock) convDone <= 1'b0;
    cyc(3);
    chk({7'h00, measure.adcPower}, 8'h00, "converter off after conversion");
    $display("test conversion done");
  endtask

  // cell flags masked by series count, summaries and parity pass-through
  task automatic t_flags();
    @(posedge clock) begin
      cellOverRaw <= 6'h3F;
      cellUnderRaw <= 6'h24;
      seriesCount <= 2'b10;
      parityLow <= 8'hA5;
      parityHigh <= 4'h9;
    end
    cyc(3);
    rdchk(OFS_OVER, 8'h0F, "over flags four cells");
    rdchk(OFS_UNDER, 8'h04, "under flags four cells");
    chk({6'h00, overvoltageSummary, undervoltageSummary}, 8'h03, "summaries");
    rdchk(OFS_PAR_LOW, 8'hA5, "parity low");
    rdchk(OFS_PAR_HIGH, 8'h09, "parity high");
    @(posedge clock) seriesCount <= 2'b11;
    cyc(3);
    rdchk(OFS_OVER, 8'h07, "over flags three cells");
    @(posedge clock) seriesCount <= 2'b01;
    cyc(3);
    rdchk(OFS_OVER, 8'h1F, "over flags five cells");
    @(posedge clock) seriesCount <= 2'b00;
    cyc(3);
    rdchk(OFS_OVER, 8'h3F, "over flags six cells");
    $display("test flags done");
  endtask

  // pin outputs, gpio input level, low power and the settle delay after it
  task automatic t_pin();
    i_cmr_host_model.wr(OFS_PIN, 8'hC7);
    cyc(4);
    chk({auxConnect, gpioDriveEn_n, 3'h0, lowPower, sensorGround}, 8'hC7,
        "pin outputs");
    rdchk(OFS_PIN, 8'hE7, "pin high readback");
    rdchk(OFS_OVER, 8'h00, "flags off in low power");
    @(posedge clock) extLow <= 1'b1;
    cyc(4);
    rdchk(OFS_PIN, 8'hC7, "pin low readback");
    chk({7'h00, monitorActive}, 8'h00, "comparators off");
    i_cmr_host_model.wr(OFS_PIN, 8'h40);
    cyc(SETTLE - 5);
    chk({7'h00, monitorActive}, 8'h00, "still settling");
    cyc(10);
    chk({7'h00, monitorActive}, 8'h01, "monitoring resumed");
    rdchk(OFS_OVER, 8'h3F, "flags back");
    @(posedge clock) extLow <= 1'b0;
    $display("test pin done");
  endtask

  // key gating, key kept by reads and cleared by other writes, and the reload request
  task automatic t_prot();
    int p0;
    p0 = protCnt;
    i_cmr_host_model.wr(8'h41, 8'h11);
    cyc(2);
    chk(8'(protCnt - p0), 8'h00, "locked write refused");
    i_cmr_host_model.prot_wr(8'h4F, 8'h5A);
    cyc(2);
    chk(8'(protCnt - p0), 8'h01, "unlocked write taken");
    chk(protAddr, 8'h4F, "protected address");
    chk(protData, 8'h5A, "protected data");
    i_cmr_host_model.wr(OFS_KEY, KEY_UNLOCK);
    rdchk(OFS_KEY, 8'h00, "key reads zero");
    i_cmr_host_model.wr(8'h40, 8'h22);
    cyc(2);
    chk(8'(protCnt - p0), 8'h02, "read keeps key open");
    i_cmr_host_model.wr(OFS_KEY, KEY_UNLOCK);
    i_cmr_host_model.wr(OFS_BAL_TIME, 8'h00);
    i_cmr_host_model.wr(8'h40, 8'h33);
    cyc(2);
    chk(8'(protCnt - p0), 8'h02, "other write closes key");
    i_cmr_host_model.wr(OFS_KEY, KEY_RELOAD);
    rdchk(OFS_KEY, 8'h00, "reload key reads zero");
    chk({7'h00, reloadReq}, 8'h01, "reload requested");
    @(posedge clock) reloadDone <= 1'b1;
    @(posedge clock) reloadDone <= 1'b0;
    cyc(2);
    chk({7'h00, reloadReq}, 8'h00, "reload finished");
    $display("test protect done");
  endtask

  // timeout in seconds, then minutes, then zero disabling the outputs
  task automatic t_bal();
    i_cmr_host_model.wr(OFS_BAL_TIME, 8'h02);
    i_cmr_host_model.wr(OFS_BAL_EN, 8'h15);
    cyc(2 * TICK - 10);
    chk({2'b00, balancePin}, 8'h15, "balancing before timeout");
    cyc(20);
    chk({2'b00, balancePin}, 8'h00, "balancing after timeout");
    i_cmr_host_model.wr(OFS_BAL_TIME, 8'h81);
    rdchk(OFS_BAL_TIME, 8'h81, "time readback");
    cyc(MINUTE_SECONDS * TICK - 12);
    chk({2'b00, balancePin}, 8'h15, "minute scale running");
    cyc(20);
    chk({2'b00, balancePin}, 8'h00, "minute scale expired");
    i_cmr_host_model.wr(OFS_BAL_TIME, 8'h00);
    cyc(3);
    chk({2'b00, balancePin}, 8'h00, "zero time disables");
    rdchk(OFS_BAL_EN, 8'h15, "enable readback");
    $display("test balance done");
  endtask

  // broadcast address and the assigned flag
  task automatic t_addr();
    i_cmr_host_model.assign_addr(ADDR_BROADCAST);
    cyc(1);
    chk({addressAssigned, 1'b0, linkAddress}, 8'hBF, "address assigned");
    rdchk(OFS_ADDR, 8'hBF, "address readback");
    $display("test address done");
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reset for 10 cycles, then each scenario in turn
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_setup();
    t_conversion_start_bit();
    t_flags();
    t_pin();
    t_prot();
    t_bal();
    t_addr();
    results();
  end
endmodule
